// ---- hdl/asc_cfg.svh ----
// constants of the converter sequencing block: offsets, fields, codes
// assumes a 16-bit register port with a 4-bit word address
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
// ============================================================
// register word addresses
`define ASC_OFS_CTRL       4'h0
`define ASC_OFS_CFG        4'h1
// ============================================================
// control register field positions
`define ASC_CTRL_SRC_HI    7
`define ASC_CTRL_SRC_LO    5
`define ASC_CTRL_GRP       4
`define ASC_CTRL_SIMULTANEOUS_SAMPLE_SELECT    3
`define ASC_CTRL_AUTO_SAMPLE_START      2
`define ASC_CTRL_SAMPLE    1
`define ASC_CTRL_DONE      0
// configuration register field positions
`define ASC_CFG_CHANNEL_COUNT_SELECT_HI    1
`define ASC_CFG_CHANNEL_COUNT_SELECT_LO    0
`define ASC_CFG_12BIT      2
`define ASC_CFG_POL        3
`define ASC_CFG_STIME_HI   8
`define ASC_CFG_STIME_LO   4
// ============================================================
// reset values
`define ASC_RST_CTRL       8'h00
`define ASC_RST_CFG        9'h0FF
// ============================================================
// trigger source codes
`define ASC_SRC_MANUAL     3'h0
`define ASC_SRC_PIN        3'h1
`define ASC_SRC_TMR3       3'h2
`define ASC_SRC_PWM_PRI    3'h3
`define ASC_SRC_TMR5       3'h4
`define ASC_SRC_PWM_SEC    3'h5
`define ASC_SRC_RSVD       3'h6
`define ASC_SRC_AUTO       3'h7
`endif

// ---- hdl/asc_pkg.sv ----
// types shared by the converter sequencing block
// assumes asc_cfg.svh supplies every numeric constant
package asc_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_START,
      ST_WAIT
   } asc_state_t;
endpackage

// ---- hdl/asc_ctrl.sv ----
// sample and conversion sequencer for one analog-to-digital converter
// assumes triggers and converter answer run on sys_clk; only the
// external interrupt pin is asynchronous and is synchronised here
`include "asc_cfg.svh"

module asc_ctrl #(
   parameter int PWM_GENS = 7   // pwm generators in group 1
) (
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   input  wire logic [3:0]          reg_addr,
   input  wire logic [15:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [15:0]         reg_rdata,
   input  wire logic                timer3_compare,
   input  wire logic                timer5_compare,
   input  wire logic                pwm_primary_event,
   input  wire logic                pwm_secondary_event,
   input  wire logic [PWM_GENS-1:0] pwm_gen_trigger,
   input  wire logic                external_interrupt_pin_zero,
   input  wire logic                conv_done,
   output logic                     conv_start,
   output logic      [1:0]          conv_channel,
   output logic      [3:0]          sh_sampling,
   output logic                     sample_active,
   output logic                     conversion_complete
);

   // ============================================================
   // declarations
   logic [2:0]            trigger_source_select_reg;  // source code
   logic                  trigger_source_group_reg;   // source group
   logic                  simultaneous_sample_select_reg;
   logic                  auto_sample_start_reg;      // auto restart
   logic                  done_reg;                   // complete flag
   logic [1:0]            channel_count_select_reg;   // 1, 2 or 4 ch
   logic                  twelve_bit_mode_reg;        // 12-bit mode
   logic                  pin_pol_reg;                // active edge
   logic [4:0]            sample_time_reg;            // auto sample len
   logic [4:0]            auto_cnt_reg;               // sample counter
   logic                  pin_s1_reg;                 // pin sync stage 1
   logic                  pin_s2_reg;                 // pin sync stage 2
   logic                  pin_s3_reg;                 // pin sync stage 3
   logic                  pin_level_reg;              // accepted level
   logic                  pin_edge_reg;               // active edge seen
   asc_pkg::asc_state_t   state_reg;
   asc_pkg::asc_state_t   state_next;
   logic [1:0]            chan_reg;                   // channel in work
   logic [1:0]            chan_next;
   logic                  sample_active_reg;
   logic                  conv_start_reg;
   logic [3:0]            sh_sampling_reg;
   logic [15:0]           rdata_reg;
   logic                  wr_ctrl;                    // control write
   logic                  wr_cfg;                     // config write
   logic                  sw_set_sample;              // software start
   logic                  sw_end_sample;              // software convert
   logic                  manual_mode;                // code 000 group 0
   logic                  trig_hit;                   // selected trigger
   logic                  auto_hit;                   // counter expired
   logic                  last_chan;                  // final channel
   logic                  done_set;                   // conversion over
   logic                  begin_conv;                 // sampling ends
   logic                  simultaneous_sample_select_eff;                 // simultaneous_sample_select in force
   logic [1:0]            chan_last;                  // last channel idx

   assign wr_ctrl     = reg_wr && (reg_addr == `ASC_OFS_CTRL);
   assign wr_cfg      = reg_wr && (reg_addr == `ASC_OFS_CFG);
   assign manual_mode = !trigger_source_group_reg &&
                        (trigger_source_select_reg == `ASC_SRC_MANUAL);

   // ============================================================
   // channel count and simultaneous select
   // 00 one channel, 01 two channels, 1x four channels
   always_comb begin
      unique case (channel_count_select_reg)
         2'h0:    chan_last = 2'h0;
         2'h1:    chan_last = 2'h1;
         default: chan_last = 2'h3;
      endcase
   end

   // ignored with one channel and absent in twelve-bit mode
   assign simultaneous_sample_select_eff = simultaneous_sample_select_reg &&
                       !twelve_bit_mode_reg &&
                       (channel_count_select_reg != 2'h0);

   // ============================================================
   // external pin synchroniser
   // three stages; a new level is accepted only when stages two and
   // three agree, which also rejects single-cycle glitches
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_s3_reg <= 1'b0;
      end else begin
         pin_s1_reg <= external_interrupt_pin_zero;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   // accepted level and its active transition
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_level_reg <= 1'b0;
         pin_edge_reg  <= 1'b0;
      end else begin
         pin_edge_reg <= 1'b0;
         if (pin_s2_reg == pin_s3_reg) begin
            pin_level_reg <= pin_s2_reg;
            // active transition only, the other one is ignored
            pin_edge_reg  <= (pin_s2_reg != pin_level_reg) &&
                             (pin_s2_reg == pin_pol_reg);
         end
      end
   end

   // ============================================================
   // trigger selection
   always_comb begin
      trig_hit = 1'b0;
      if (trigger_source_group_reg) begin
         // group 1: generators one to seven, top code reserved
         if (trigger_source_select_reg < 3'(PWM_GENS))
            trig_hit = pwm_gen_trigger[trigger_source_select_reg];
      end else begin
         unique case (trigger_source_select_reg)
            `ASC_SRC_MANUAL:  trig_hit = 1'b0;
            `ASC_SRC_PIN:     trig_hit = pin_edge_reg;
            `ASC_SRC_TMR3:    trig_hit = timer3_compare;
            `ASC_SRC_PWM_PRI: trig_hit = pwm_primary_event;
            `ASC_SRC_TMR5:    trig_hit = timer5_compare;
            `ASC_SRC_PWM_SEC: trig_hit = pwm_secondary_event;
            `ASC_SRC_RSVD:    trig_hit = 1'b0;
            `ASC_SRC_AUTO:    trig_hit = auto_hit;
         endcase
      end
   end

   // ============================================================
   // internal sample counter for auto-convert
   // runs only while sampling; sample length is field value plus one
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         auto_cnt_reg <= 5'h00;
      end else if (state_reg == asc_pkg::ST_SAMPLE && !auto_hit) begin
         auto_cnt_reg <= auto_cnt_reg + 5'h01;
      end else begin
         auto_cnt_reg <= 5'h00;
      end
   end

   assign auto_hit = (state_reg == asc_pkg::ST_SAMPLE) &&
                     (auto_cnt_reg == sample_time_reg);

   // ============================================================
   // software start and end of sampling
   // start only from idle with auto start off; the device never sets
   // the sample bit itself in that case
   assign sw_set_sample = wr_ctrl && reg_wdata[`ASC_CTRL_SAMPLE] &&
                          !auto_sample_start_reg &&
                          (state_reg == asc_pkg::ST_IDLE);
   assign sw_end_sample = wr_ctrl && !reg_wdata[`ASC_CTRL_SAMPLE] &&
                          manual_mode &&
                          (state_reg == asc_pkg::ST_SAMPLE);
   assign last_chan     = (chan_reg == chan_last);
   assign done_set      = (state_reg == asc_pkg::ST_WAIT) &&
                          conv_done && last_chan;

   // ============================================================
   // sequencer next state
   always_comb begin
      state_next = state_reg;
      chan_next  = chan_reg;
      begin_conv = 1'b0;
      unique case (state_reg)
         asc_pkg::ST_IDLE: begin
            // auto start also kicks off when first enabled
            if (auto_sample_start_reg || sw_set_sample)
               state_next = asc_pkg::ST_SAMPLE;
         end
         asc_pkg::ST_SAMPLE: begin
            if (manual_mode ? sw_end_sample : trig_hit) begin
               state_next = asc_pkg::ST_START;
               chan_next  = 2'h0;
               begin_conv = 1'b1;
            end
         end
         asc_pkg::ST_START: begin
            state_next = asc_pkg::ST_WAIT;
         end
         asc_pkg::ST_WAIT: begin
            if (conv_done) begin
               if (!last_chan) begin
                  state_next = asc_pkg::ST_START;
                  chan_next  = chan_reg + 2'h1;
               end else if (auto_sample_start_reg) begin
                  state_next = asc_pkg::ST_SAMPLE;
               end else begin
                  state_next = asc_pkg::ST_IDLE;
               end
            end
         end
      endcase
   end

   // state, channel and start strobe
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg      <= asc_pkg::ST_IDLE;
         chan_reg       <= 2'h0;
         conv_start_reg <= 1'b0;
      end else begin
         state_reg      <= state_next;
         chan_reg       <= chan_next;
         conv_start_reg <= (state_next == asc_pkg::ST_START);
      end
   end

   // ============================================================
   // sample bit and per-channel sample/hold controls
   // simultaneous: every channel holds at the trigger; sequential:
   // a channel keeps sampling until its own conversion starts
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sample_active_reg <= 1'b0;
         sh_sampling_reg   <= 4'h0;
      end else begin
         sample_active_reg <= (state_next == asc_pkg::ST_SAMPLE);
         for (int i = 0; i < 4; i++) begin
            if (2'(i) > chan_last)
               sh_sampling_reg[i] <= 1'b0;
            else if (state_next == asc_pkg::ST_SAMPLE)
               sh_sampling_reg[i] <= 1'b1;
            else if (state_next == asc_pkg::ST_IDLE || simultaneous_sample_select_eff)
               sh_sampling_reg[i] <= 1'b0;
            else
               sh_sampling_reg[i] <= (2'(i) > chan_next) &&
                                     sh_sampling_reg[i];
         end
      end
   end

   // ============================================================
   // conversion-complete flag
   // hardware set wins over a software clear in the same cycle; a
   // written one never sets it, and a clear does not touch the
   // sequencer; clearing it under auto start is legal but unwise
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         done_reg <= 1'b0;
      end else if (done_set) begin
         done_reg <= 1'b1;
      end else if (begin_conv) begin
         done_reg <= 1'b0;
      end else if (wr_ctrl && !reg_wdata[`ASC_CTRL_DONE]) begin
         done_reg <= 1'b0;
      end
   end

   // ============================================================
   // control register fields
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         {trigger_source_select_reg, trigger_source_group_reg,
          simultaneous_sample_select_reg, auto_sample_start_reg} <=
            6'(`ASC_RST_CTRL >> `ASC_CTRL_AUTO_SAMPLE_START);
      end else if (wr_ctrl) begin
         trigger_source_select_reg <=
            reg_wdata[`ASC_CTRL_SRC_HI:`ASC_CTRL_SRC_LO];
         trigger_source_group_reg       <= reg_wdata[`ASC_CTRL_GRP];
         simultaneous_sample_select_reg <= reg_wdata[`ASC_CTRL_SIMULTANEOUS_SAMPLE_SELECT];
         auto_sample_start_reg          <= reg_wdata[`ASC_CTRL_AUTO_SAMPLE_START];
      end
   end

   // configuration register fields
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         {sample_time_reg, pin_pol_reg, twelve_bit_mode_reg,
          channel_count_select_reg} <= `ASC_RST_CFG;
      end else if (wr_cfg) begin
         channel_count_select_reg <=
            reg_wdata[`ASC_CFG_CHANNEL_COUNT_SELECT_HI:`ASC_CFG_CHANNEL_COUNT_SELECT_LO];
         twelve_bit_mode_reg <= reg_wdata[`ASC_CFG_12BIT];
         pin_pol_reg         <= reg_wdata[`ASC_CFG_POL];
         sample_time_reg     <=
            reg_wdata[`ASC_CFG_STIME_HI:`ASC_CFG_STIME_LO];
      end
   end

   // ============================================================
   // read port: data one cycle after the strobe, zero elsewhere
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 16'h0000;
      end else if (reg_rd && reg_addr == `ASC_OFS_CTRL) begin
         rdata_reg <= {8'h00, trigger_source_select_reg,
                       trigger_source_group_reg,
                       simultaneous_sample_select_reg &&
                       !twelve_bit_mode_reg,
                       auto_sample_start_reg, sample_active_reg,
                       done_reg};
      end else if (reg_rd && reg_addr == `ASC_OFS_CFG) begin
         rdata_reg <= {7'h00, sample_time_reg, pin_pol_reg,
                       twelve_bit_mode_reg, channel_count_select_reg};
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign reg_rdata           = rdata_reg;
   assign conv_start          = conv_start_reg;
   assign conv_channel        = chan_reg;
   assign sh_sampling         = sh_sampling_reg;
   assign sample_active       = sample_active_reg;
   assign conversion_complete = done_reg;

   // ============================================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sample_state_a: assert property (
      sample_active == (state_reg == asc_pkg::ST_SAMPLE))
      else $error("sample bit disagrees with sequencer");
   manual_end_a: assert property (
      sw_end_sample |=> !sample_active && conv_start && conv_channel == 0)
      else $error("manual clear did not start conversion");
   trigger_end_a: assert property (
      (state_reg == asc_pkg::ST_SAMPLE && !manual_mode && trig_hit)
      |=> !sample_active ##0 conv_start)
      else $error("trigger did not end sampling");
   reserved_code_a: assert property (
      (state_reg == asc_pkg::ST_SAMPLE && !trigger_source_group_reg &&
       trigger_source_select_reg == `ASC_SRC_RSVD && !reg_wr)
      |=> sample_active)
      else $error("reserved source ended sampling");
   auto_restart_a: assert property (
      (done_set && auto_sample_start_reg) |=> sample_active && done_reg)
      else $error("auto start did not resample");
   no_self_set_a: assert property (
      (state_reg == asc_pkg::ST_IDLE && !auto_sample_start_reg &&
       !sw_set_sample) |=> !sample_active)
      else $error("sample bit set without software");
   done_set_a: assert property (
      done_set |=> conversion_complete [*2] or
      (conversion_complete ##1 $fell(conversion_complete)))
      else $error("done flag not set at end");
   done_clear_a: assert property (
      begin_conv |=> !conversion_complete)
      else $error("done flag survived new conversion");
   done_one_a: assert property (
      (wr_ctrl && reg_wdata[`ASC_CTRL_DONE] && !done_reg && !done_set)
      |=> !conversion_complete)
      else $error("software set the done flag");
   simultaneous_sample_select_read_a: assert property (
      (reg_rd && reg_addr == `ASC_OFS_CTRL && twelve_bit_mode_reg)
      |=> !reg_rdata[`ASC_CTRL_SIMULTANEOUS_SAMPLE_SELECT])
      else $error("simultaneous_sample_select visible in twelve-bit mode");
   simultaneous_sample_select_hold_a: assert property (
      (begin_conv && simultaneous_sample_select_eff && !wr_cfg) |=> sh_sampling == 4'h0)
      else $error("simultaneous channels not all holding");
   seq_order_a: assert property (
      (begin_conv && !simultaneous_sample_select_eff && chan_last == 2'h3 && !wr_cfg)
      |=> sh_sampling == 4'hE)
      else $error("sequential sampling order wrong");

   manual_cov_c:  cover property (sw_end_sample ##[1:40] done_set);
   pin_cov_c:     cover property (pin_edge_reg && trig_hit);
   simul_cov_c:   cover property (begin_conv && simultaneous_sample_select_eff &&
                                  chan_last == 2'h3);
   restart_cov_c: cover property (done_set && auto_sample_start_reg);

endmodule

// ---- dv/asc_conv_model.sv ----
// stand-in converter: one finish pulse for every start pulse
// assumes conv_start is a one-cycle pulse on sys_clk
module asc_conv_model (
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic       conv_start,
   input  wire logic [3:0] lat,
   output logic            conv_done
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // busy countdown
   logic [4:0] cnt_reg; // cycles left, zero when idle
   // lat gives prompt or slow answers; never in the start cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg   <= 5'h00;
         conv_done <= 1'b0;
      end else begin
         conv_done <= (cnt_reg == 5'h01);
         if (conv_start) begin
            cnt_reg <= {1'b0, lat} + 5'h01;
         end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
         end
      end
   end
endmodule

// ---- dv/tb_adc_sample_convert_control.sv ----
// bench for the converter sequencer: registers, triggers, sequences
// assumes asc_ctrl on one clock beside the stand-in converter
`include "asc_cfg.svh"
module tb_adc_sample_convert_control;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // signals
   logic        sys_clk = 1'b0;      // 5 ns period
   logic        reset_n = 1'b0;      // active low
   logic [3:0]  addr = 4'h0;         // register word address
   logic [15:0] wdata = 16'h0000;    // write data
   logic        wr = 1'b0;           // write strobe
   logic        rd = 1'b0;           // read strobe
   logic [15:0] rdata;               // read data
   logic [11:0] trg = 12'h000;       // pin, timers, pwm, generators
   logic        pin_hold = 1'b0;     // pin kept one more cycle
   logic [3:0]  lat = 4'h0;          // converter answer delay
   logic        conv_done;           // channel finished
   logic        conv_start;          // channel start
   logic [1:0]  conv_channel;        // channel converted
   logic [3:0]  sh_sampling;         // per-channel sampling
   logic        sample_active;       // sample bit
   logic        conversion_complete; // done flag
   logic [15:0] got;                 // last read value
   int          fails = 0;           // mismatches
   int          num_checks = 0;      // comparisons
   always #2.5 sys_clk = ~sys_clk;
   // the pin filter drops one-cycle pulses, so the pin is stretched
   always @(posedge sys_clk) pin_hold <= trg[0];
   asc_ctrl dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .timer3_compare(trg[1]), .timer5_compare(trg[3]),
      .pwm_primary_event(trg[2]), .pwm_secondary_event(trg[4]),
      .pwm_gen_trigger(trg[11:5]),
      .external_interrupt_pin_zero(trg[0] | pin_hold),
      .conv_done(conv_done), .conv_start(conv_start),
      .conv_channel(conv_channel), .sh_sampling(sh_sampling),
      .sample_active(sample_active),
      .conversion_complete(conversion_complete));
   asc_conv_model model (.sys_clk(sys_clk), .reset_n(reset_n),
      .conv_start(conv_start), .lat(lat), .conv_done(conv_done));
   // ==========================================
   // shared tasks
   task automatic chk(input logic [15:0] g, input logic [15:0] e,
                      input string m);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // a used-up wait bound counts as a mismatch and ends the run
   task automatic tmo(input int n);
      if (n >= 60) begin
         chk(16'h0001, 16'h0000, "timeout");
         print_verdict;
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      got = rdata;
   endtask
   task automatic pulse(input logic [11:0] m);
      @(posedge sys_clk);
      trg <= m;
      @(posedge sys_clk);
      trg <= 12'h000;
   endtask
   // walk every channel start, then wait for the done flag
   task automatic convert(input int nch, input logic sim, input logic now);
      int n;
      int i;
      logic [15:0] e;
      if (!now) begin
         @(negedge sys_clk);
      end
      for (i = 0; i < nch; i++) begin
         for (n = 0; n < 60 && conv_start !== 1'b1; n++) begin
            @(negedge sys_clk);
         end
         tmo(n);
         chk({14'h0, conv_channel}, 16'(i), "channel");
         e = ((16'h0001 << nch) - 16'h0001) & ~((16'h0002 << i) - 16'h1);
         chk({12'h0, sh_sampling}, sim ? 16'h0 : e, "hold");
         chk({15'h0, conversion_complete}, 16'h0, "done clr");
         chk({15'h0, sample_active}, 16'h0, "sample end");
         @(negedge sys_clk);
      end
      for (n = 0; n < 60 && conversion_complete !== 1'b1; n++) begin
         @(negedge sys_clk);
      end
      tmo(n);
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset;
      rd_reg(`ASC_OFS_CTRL);
      chk(got, {8'h00, `ASC_RST_CTRL}, "ctrl reset");
      rd_reg(`ASC_OFS_CFG);
      chk(got, {7'h00, `ASC_RST_CFG}, "cfg reset");
      wr_reg(4'hF, 16'hFFFF);
      rd_reg(4'hF);
      chk(got, 16'h0000, "unmapped");
      wr_reg(`ASC_OFS_CTRL, 16'h0008);
      rd_reg(`ASC_OFS_CTRL);
      chk(got, 16'h0000, "simultaneous_sample_select 12b");
      $display("t_reset done");
   endtask
   task automatic t_manual;
      lat <= 4'h3;
      wr_reg(`ASC_OFS_CFG, 16'h00FB);
      wr_reg(`ASC_OFS_CTRL, 16'h0002);
      rd_reg(`ASC_OFS_CTRL);
      chk(got, 16'h0002, "sample set");
      wr_reg(`ASC_OFS_CTRL, 16'h0000);
      convert(4, 1'b0, 1'b0);
      wr_reg(`ASC_OFS_CTRL, 16'h0001);
      rd_reg(`ASC_OFS_CTRL);
      chk(got, 16'h0001, "done kept");
      wr_reg(`ASC_OFS_CTRL, 16'h0000);
      rd_reg(`ASC_OFS_CTRL);
      chk(got, 16'h0000, "sw clear");
      wr_reg(`ASC_OFS_CTRL, 16'h0001);
      rd_reg(`ASC_OFS_CTRL);
      chk(got, 16'h0000, "done write one");
      $display("t_manual done");
   endtask
   // each source ignores the others but the pin, then fires on its own event
   task automatic t_triggers;
      int k;
      logic [7:0] c;
      wr_reg(`ASC_OFS_CFG, 16'h00F9);
      for (k = 0; k < 12; k++) begin
         c = (k < 5) ? 8'((k + 1) << 5) : 8'(((k - 5) << 5) | 16);
         lat <= 4'(k);
         wr_reg(`ASC_OFS_CTRL, {8'h00, c | 8'h0A});
         pulse(~(12'h001 << k) & 12'hFFE);
         repeat (8) @(negedge sys_clk);
         chk({15'h0, sample_active}, 16'h0001, "held");
         pulse(12'h001 << k);
         convert(2, 1'b1, 1'b0);
      end
      for (k = 0; k < 2; k++) begin
         wr_reg(`ASC_OFS_CTRL, k ? 16'h00F2 : 16'h00C2);
         pulse(12'hFFF);
         repeat (8) @(negedge sys_clk);
         chk({15'h0, sample_active}, 16'h0001, "reserved");
         wr_reg(`ASC_OFS_CTRL, 16'h0002);
         wr_reg(`ASC_OFS_CTRL, 16'h0000);
         convert(2, 1'b0, 1'b0);
      end
      // falling edge selected: the rising one must not end sampling
      wr_reg(`ASC_OFS_CFG, 16'h00F1);
      wr_reg(`ASC_OFS_CTRL, 16'h0022);
      pulse(12'h001);
      repeat (5) @(negedge sys_clk);
      chk({15'h0, sample_active}, 16'h0001, "rise ignored");
      convert(2, 1'b0, 1'b0);
      $display("t_triggers done");
   endtask
   task automatic t_auto;
      int n;
      logic [15:0] c;
      wr_reg(`ASC_OFS_CFG, 16'h00FB);
      lat <= 4'h1;
      wr_reg(`ASC_OFS_CTRL, 16'h00EC);
      c = 16'h0000;
      for (n = 0; n < 60 && conv_start !== 1'b1; n++) begin
         @(negedge sys_clk);
         c = c + {15'h0, sample_active === 1'b1};
      end
      tmo(n);
      chk(c, 16'h0010, "sample time");
      convert(4, 1'b1, 1'b1);
      chk({15'h0, sample_active}, 16'h0001, "resample");
      wr_reg(`ASC_OFS_CTRL, 16'h00E9);
      convert(4, 1'b1, 1'b0);
      repeat (20) @(negedge sys_clk);
      chk({15'h0, sample_active}, 16'h0000, "no restart");
      $display("t_auto done");
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset;
      t_manual;
      t_triggers;
      t_auto;
      print_verdict;
   end
endmodule
